// file: mad_checker.sv
/*
  Port checker of the multiply-accumulate datapath.
  Assumes a bind from the bench top file and one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mad_params.svh"
module mad_checker
  import mad_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic opValid,
  input wire mad_op_t opCode,
  input wire logic [7:0] repeatCount,
  input wire logic opOffChip,
  input wire logic [15:0] offChipData,
  input wire logic busy,
  input wire logic [31:0] accum,
  input wire logic [31:0] productReg,
  input wire logic [15:0] tempReg,
  input wire logic blockZeroProgram,
  input wire logic [1:0] statusProductShift
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic tk;
  logic tko;
  assign tk = opValid && !busy && repeatCount == 8'h00;
  assign tko = tk && opOffChip;
  function automatic logic [31:0] sm(logic signed [15:0] a, logic signed [15:0] b);
    logic signed [31:0] x;
    x = a;
    return x * b;
  endfunction
  // Field 3 shifts right arithmetically, keeping the sign; fields 1 and 2 shift left
  function automatic logic [31:0] shf(logic [1:0] m, logic [31:0] p);
    case (m)
      2'h1: return p << 1;
      2'h2: return p << 4;
      2'h3: return $signed(p) >>> 6;
      default: return p;
    endcase
  endfunction
  sequence s_rep3;
    opValid && !busy && repeatCount == 8'h02;
  endsequence
  sequence s_fill_run3;
    busy [*5] ##1 !busy;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_signed_mul:
    assert property (tko && opCode == `MAD_OP_SIGNED_MULTIPLY |=> productReg == sm($past(tempReg), $past(offChipData)))
      else $error("signed product wrong");
  a_unsigned_mul:
    assert property (tko && opCode == `MAD_OP_UNSIGNED_MULTIPLY |=> productReg == $past(tempReg) * $past(offChipData))
      else $error("unsigned product wrong");
  a_square_add:
    assert property (tko && opCode == `MAD_OP_SQUARE_AND_ADD |=> productReg == sm($past(offChipData), $past(offChipData))
      && accum == $past(accum) + shf($past(statusProductShift), $past(productReg))) else $error("square add wrong");
  a_square_sub:
    assert property (tko && opCode == `MAD_OP_SQUARE_AND_SUBTRACT |=>
      accum == $past(accum) - shf($past(statusProductShift), $past(productReg))) else $error("square sub wrong");
  a_map_program:
    assert property (tk && opCode == `MAD_OP_MAP_BLOCK_ZERO_PROGRAM |=> blockZeroProgram) else $error("map prog");
  a_map_data:
    assert property (tk && opCode == `MAD_OP_MAP_BLOCK_ZERO_DATA |=> !blockZeroProgram) else $error("map data");
  a_product_hold:
    assert property (!opValid && !busy |=> $stable(productReg)) else $error("product changed");
  a_repeat_timing:
    assert property (s_rep3 |=> s_fill_run3) else $error("repeat timing");
endmodule
`default_nettype wire

// file: mad_datapath.sv
/*
  Multiply-accumulate datapath with temporary operand register, product
  register, product shifter, accumulator, three on-chip RAM blocks with the
  copy-word-up delay line, block-zero mapping and repeat sequencing.
  Assumes a decoder that issues one op per cycle with an operand address it
  has already computed (the address arithmetic unit is outside) and a data
  word for off-chip operands; the program-side coefficient is read from block
  zero at progAddr while block zero is mapped as program and progOffChip is low, else taken from progData.
  A nonzero repeat count latches the op and replays it after a two-cycle
  fill, one pass per cycle, the data address stepping down and the
  coefficient index stepping up. Busy is high exactly while the sequencer
  is away from idle, so the decoder holds a further op until busy is low.
  Host RAM writes share one write port with the delay-line copy and count
  only while idle. The RAM is not cleared by reset, and the top word is
  never copied because it has no higher neighbour. Accumulation wraps;
  there is no saturation here.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mad_params.svh"

// Functional notes
// - Copy addressed RAM word to next address
// - Move and arithmetic share one cycle
// - Copy crosses block boundaries seamlessly
// - No copy for off-chip operands
// - Three move instructions perform the copy
// - Move-MAC equals MAC then separate move
// - Move-MAC runs under repeat prefix
// - Default multiply signed, 32-bit, one cycle
// - Unsigned multiply gives full unsigned product
// - Temp register times operand into product
// - Each multiply overwrites product register
// - MAC adds product, then multiplies operands
// - MAC coefficient from block zero as program
// - Instructions map block zero program/data
// - Repeated MAC takes three plus N cycles
// - Square add/subtract then square operand
// - Product shift field shifts transfer only
// - Field 11 arithmetic right shift six

module mad_datapath
  import mad_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic opValid,
  input wire mad_op_t opCode,
  input wire logic [7:0] repeatCount,
  input wire logic opOffChip,
  input wire logic [`MAD_ADDR_W:0] dataAddr,
  input wire logic [15:0] dataIn,
  input wire logic [15:0] offChipData,
  input wire logic progOffChip,
  input wire logic [`MAD_ADDR_W-1:0] progAddr,
  input wire logic [15:0] progData,
  input wire logic [1:0] productShiftField,
  input wire logic ramWriteEn,
  output logic busy,
  output logic [31:0] accum,
  output logic [31:0] productReg,
  output logic [15:0] tempReg,
  output logic [15:0] operandOut,
  output logic blockZeroProgram,
  output logic [1:0] statusProductShift
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage and state

  logic [15:0] ram [0:`MAD_RAM_WORDS-1];
  logic [31:0] accum_r;
  logic [31:0] product_r;
  logic [15:0] temp_r;
  logic [15:0] operand_r;
  logic blkZeroProg_r;
  logic [1:0] pmField_r;
  mad_state_t state_r;
  logic [7:0] rptLeft_r;
  logic [1:0] fillCnt_r;
  mad_op_t rptOp_r;
  logic [`MAD_ADDR_W:0] rptAddr_r;
  logic [`MAD_ADDR_W-1:0] rptProg_r;

  ////////////////////////////////////////////////////////////////////////////
  // Operation select: a repeat replays the latched op with stepping addresses

  mad_op_t curOp;
  logic curGo;
  logic [`MAD_ADDR_W:0] curAddr;
  logic [`MAD_ADDR_W-1:0] curProg;
  logic [15:0] dataWord;
  logic [15:0] coefWord;
  logic inRam;
  logic doMove;
  logic doMul;
  logic mulUnsigned;
  logic [15:0] mulB;
  logic [31:0] mulRes;
  logic [31:0] shiftedProduct;
  logic doAcc;
  logic doSub;

  always_comb begin
    curOp = (state_r == MAD_RUN) ? rptOp_r : opCode;
    curGo = (state_r == MAD_RUN) || (state_r == MAD_IDLE && opValid && repeatCount == 8'h00);
    curAddr = (state_r == MAD_RUN) ? rptAddr_r : dataAddr;
    curProg = (state_r == MAD_RUN) ? rptProg_r : progAddr;
  end

  // Off-chip operands bypass the RAM and never trigger a copy
  assign inRam = !opOffChip && (curAddr <= `MAD_RAM_LAST);
  assign dataWord = inRam ? ram[curAddr[`MAD_ADDR_W:0]] : offChipData;
  // Coefficient comes from block zero only while it is mapped as program
  assign coefWord = (blkZeroProg_r && !progOffChip) ?
    ram[{2'b00, curProg[7:0]}] : progData;

  // The last word of RAM has no higher neighbour, so it is not copied
  assign doMove = curGo && inRam && (curAddr != `MAD_RAM_LAST) &&
    (curOp == `MAD_OP_COPY_WORD_UP || curOp == `MAD_OP_LOAD_TEMP_ACCUM ||
     curOp == `MAD_OP_MUL_ACC_WITH_MOVE);

  always_comb begin
    doMul = 1'b0;
    mulUnsigned = 1'b0;
    mulB = dataWord;
    doAcc = 1'b0;
    doSub = 1'b0;
    unique case (curOp)
      `MAD_OP_SIGNED_MULTIPLY: begin
        doMul = 1'b1;
      end
      `MAD_OP_UNSIGNED_MULTIPLY: begin
        doMul = 1'b1;
        mulUnsigned = 1'b1;
      end
      `MAD_OP_MUL_ACC, `MAD_OP_MUL_ACC_WITH_MOVE: begin
        doMul = 1'b1;
        doAcc = 1'b1;
        mulB = coefWord;
      end
      `MAD_OP_SQUARE_AND_ADD: begin
        doMul = 1'b1;
        doAcc = 1'b1;
      end
      `MAD_OP_SQUARE_AND_SUBTRACT: begin
        doMul = 1'b1;
        doAcc = 1'b1;
        doSub = 1'b1;
      end
      `MAD_OP_LOAD_TEMP_ACCUM, `MAD_OP_ADD_PRODUCT_TO_ACCUM: begin
        doAcc = 1'b1;
      end
      default: ;
    endcase
  end

  // Multiplier: signed by default, unsigned magnitudes on request
  logic [15:0] mulA;
  always_comb begin
    mulA = temp_r;
    if (curOp == `MAD_OP_MUL_ACC || curOp == `MAD_OP_MUL_ACC_WITH_MOVE) begin
      mulA = dataWord;
    end else if (curOp == `MAD_OP_SQUARE_AND_ADD || curOp == `MAD_OP_SQUARE_AND_SUBTRACT) begin
      mulA = dataWord;
    end
  end

  // Multiplier core kept apart from operand steering
  always_comb begin
    if (mulUnsigned) begin
      mulRes = {16'h0000, mulA} * {16'h0000, mulB};
    end else begin
      mulRes = 32'($signed({{16{mulA[15]}}, mulA}) * $signed({{16{mulB[15]}}, mulB}));
    end
  end

  // Shifter sits only on the path to the accumulator
  always_comb begin
    unique case (pmField_r)
      `MAD_PM_NONE: begin
        shiftedProduct = product_r;
      end
      `MAD_PM_LEFT1: begin
        shiftedProduct = {product_r[30:0], 1'b0};
      end
      `MAD_PM_LEFT4: begin
        shiftedProduct = {product_r[27:0], 4'h0};
      end
      `MAD_PM_RIGHT6: begin
        shiftedProduct = {{6{product_r[31]}}, product_r[31:6]};
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Repeat sequencer
  // Only the idle state takes a new op; fill and run ignore opValid

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= MAD_IDLE;
      rptLeft_r <= 8'h00;
      fillCnt_r <= 2'h0;
      rptOp_r <= `MAD_OP_NOP;
      rptAddr_r <= '0;
      rptProg_r <= '0;
    end else begin
      unique case (state_r)
        MAD_IDLE: if (opValid && repeatCount != 8'h00) begin
          // Repeat count N-1 gives N passes after the pipeline fill
          state_r <= MAD_FILL;
          rptLeft_r <= repeatCount;
          fillCnt_r <= `MAD_RPT_OVERHEAD;
          rptOp_r <= opCode;
          rptAddr_r <= dataAddr;
          rptProg_r <= progAddr;
        end
        MAD_FILL: begin
          // Fill covers the operand fetch and multiplier latency
          fillCnt_r <= fillCnt_r - 2'h1;
          if (fillCnt_r == 2'h1) begin
            state_r <= MAD_RUN;
          end
        end
        MAD_RUN: begin
          // Each later pass takes one cycle; data walks down like post-decrement
          rptAddr_r <= rptAddr_r - 10'h001;
          rptProg_r <= rptProg_r + 9'h001;
          rptLeft_r <= rptLeft_r - 8'h01;
          if (rptLeft_r == 8'h00) begin
            state_r <= MAD_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic registers, all updated in the operation's single cycle

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      product_r <= 32'h0000_0000;
    end else if (curGo && doMul) begin
      product_r <= mulRes;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      accum_r <= 32'h0000_0000;
    end else if (curGo && curOp == `MAD_OP_CLEAR_ACCUM) begin
      accum_r <= 32'h0000_0000;
    end else if (curGo && doAcc) begin
      // Old product is accumulated before the new multiply lands
      accum_r <= doSub ? accum_r - shiftedProduct : accum_r + shiftedProduct;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      temp_r <= 16'h0000;
    end else if (curGo && (curOp == `MAD_OP_LOAD_TEMP || curOp == `MAD_OP_LOAD_TEMP_ACCUM)) begin
      temp_r <= dataWord;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      operand_r <= 16'h0000;
    end else if (curGo) begin
      operand_r <= dataWord;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      blkZeroProg_r <= 1'b0;
    end else if (curGo && curOp == `MAD_OP_MAP_BLOCK_ZERO_PROGRAM) begin
      blkZeroProg_r <= 1'b1;
    end else if (curGo && curOp == `MAD_OP_MAP_BLOCK_ZERO_DATA) begin
      blkZeroProg_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pmField_r <= `MAD_PM_NONE;
    end else begin
      // Registered, so a field change applies from the next cycle's op
      pmField_r <= productShiftField;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RAM: the copy runs the same edge as the arithmetic, one flat array so
  // a word at a block's end lands in the next block's first word

  logic ramWe;
  logic [`MAD_ADDR_W:0] ramWAddr;
  logic [15:0] ramWData;

  // One write port; the copy wins over a host write in the same cycle
  always_comb begin
    ramWe = 1'b0;
    ramWAddr = dataAddr;
    ramWData = dataIn;
    if (doMove) begin
      ramWe = 1'b1;
      ramWAddr = curAddr + 10'h001;
      ramWData = dataWord;
    end else if (ramWriteEn && state_r == MAD_IDLE && dataAddr <= `MAD_RAM_LAST) begin
      ramWe = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (ramWe) begin
      ram[ramWAddr] <= ramWData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy <= 1'b0;
    end else begin
      // Mirrors the next state, so busy low always means an op is taken
      busy <= (state_r == MAD_IDLE && opValid && repeatCount != 8'h00) ||
        (state_r == MAD_FILL) || (state_r == MAD_RUN && rptLeft_r != 8'h00);
    end
  end

  assign accum = accum_r;
  assign productReg = product_r;
  assign tempReg = temp_r;
  assign operandOut = operand_r;
  assign blockZeroProgram = blkZeroProg_r;
  assign statusProductShift = pmField_r;

endmodule

`default_nettype wire

// file: mad_decoder_model.sv
/*
  Decoder and memory side model: issues ops and host RAM writes.
  Assumes the bench top holds give_verdict.
*/
`timescale 1ns/1ns
`default_nettype none
module mad_decoder_model
  import mad_pkg::*;
(
  input wire logic clk,
  input wire logic busy,
  output var logic opValid,
  output var mad_op_t opCode,
  output var logic [7:0] repeatCount,
  output var logic opOffChip,
  output var logic [9:0] dataAddr,
  output var logic [15:0] dataIn,
  output var logic [15:0] offChipData,
  output var logic progOffChip,
  output var logic [8:0] progAddr,
  output var logic [15:0] progData,
  output var logic ramWriteEn
);
  initial begin
    {opValid, opCode, repeatCount, opOffChip, dataAddr, dataIn} = '0;
    {offChipData, progAddr, progData, ramWriteEn} = '0;
    progOffChip = 1'b0;
  end
  // Held until taken; a stuck busy ends the run
  task automatic issue(input mad_op_t op, input logic off, input logic [9:0] a,
      input logic [15:0] d, input logic [7:0] n, input logic [8:0] pa);
    @(negedge clk);
    opValid = 1'b1;
    opCode = op;
    opOffChip = off;
    dataAddr = a;
    offChipData = d;
    repeatCount = n;
    progAddr = pa;
    // Busy is settled at the falling edge and is what the next rising edge sees
    for (int i = 0; busy; i++) begin
      if (i == 40) test_multiply_accumulate_datamove.give_verdict(1'b1);
      @(negedge clk);
    end
    @(negedge clk);
    opValid = 1'b0;
  endtask
  task automatic put(input logic [9:0] a, input logic [15:0] d);
    @(negedge clk);
    dataAddr = a;
    dataIn = d;
    ramWriteEn = 1'b1;
    @(negedge clk);
    ramWriteEn = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: mad_params.svh
/*
  Constants of the multiply-accumulate and data-move datapath: field positions,
  opcode values, memory map and timing counts.
  Assumes nothing of its surroundings; included by the package and the datapath.
*/
`ifndef MAD_PARAMS_SVH
`define MAD_PARAMS_SVH

`define MAD_OP_W 4
`define MAD_OP_NOP 4'h0
`define MAD_OP_LOAD_TEMP 4'h1
`define MAD_OP_SIGNED_MULTIPLY 4'h2
`define MAD_OP_UNSIGNED_MULTIPLY 4'h3
`define MAD_OP_MUL_ACC 4'h4
`define MAD_OP_MUL_ACC_WITH_MOVE 4'h5
`define MAD_OP_SQUARE_AND_ADD 4'h6
`define MAD_OP_SQUARE_AND_SUBTRACT 4'h7
`define MAD_OP_COPY_WORD_UP 4'h8
`define MAD_OP_LOAD_TEMP_ACCUM 4'h9
`define MAD_OP_ADD_PRODUCT_TO_ACCUM 4'ha
`define MAD_OP_MAP_BLOCK_ZERO_PROGRAM 4'hb
`define MAD_OP_MAP_BLOCK_ZERO_DATA 4'hc
`define MAD_OP_CLEAR_ACCUM 4'hd

`define MAD_ADDR_W 9
`define MAD_RAM_WORDS 768
`define MAD_RAM_LAST 10'h2ff
`define MAD_BLK_ZERO_BASE 10'h000
`define MAD_BLK_ONE_BASE 10'h100
`define MAD_BLK_TWO_BASE 10'h200

`define MAD_PM_LSB 0
`define MAD_PM_W 2
`define MAD_PM_NONE 2'h0
`define MAD_PM_LEFT1 2'h1
`define MAD_PM_LEFT4 2'h2
`define MAD_PM_RIGHT6 2'h3

`define MAD_RPT_OVERHEAD 2'h2

`endif

// file: mad_pkg.sv
/*
  Types of the multiply-accumulate and data-move datapath.
  Assumes mad_params.svh sits in the same folder.
*/
`include "mad_params.svh"

package mad_pkg;
  typedef logic [`MAD_OP_W-1:0] mad_op_t;
  typedef enum {MAD_IDLE, MAD_FILL, MAD_RUN} mad_state_t;
endpackage

// file: test_multiply_accumulate_datamove.sv
/*
  Self-checking bench of the datapath with decoder model and checker.
  Assumes the design, package and checker files compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mad_params.svh"
module test_multiply_accumulate_datamove
  import mad_pkg::*;
;
  logic clk, rst_b, busy, blockZeroProgram, opValid, opOffChip, progOffChip, ramWriteEn;
  logic [1:0] productShiftField, statusProductShift;
  logic [31:0] accum, productReg;
  logic [15:0] tempReg, operandOut, dataIn, offChipData, progData;
  logic [9:0] dataAddr;
  logic [8:0] progAddr;
  logic [7:0] repeatCount;
  mad_op_t opCode;
  int mismatches = 0;
  int checkCount = 0;
  mad_datapath DUT (.clk, .rst_b, .opValid, .opCode, .repeatCount, .opOffChip, .dataAddr, .dataIn,
    .offChipData, .progOffChip, .progAddr, .progData, .productShiftField, .ramWriteEn, .busy, .accum,
    .productReg, .tempReg, .operandOut, .blockZeroProgram, .statusProductShift);
  mad_decoder_model part (.clk, .busy, .opValid, .opCode, .repeatCount, .opOffChip, .dataAddr,
    .dataIn, .offChipData, .progOffChip, .progAddr, .progData, .ramWriteEn);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict(input bit hang);
    if (hang) mismatches++;
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic op(input mad_op_t c, input logic off, input logic [9:0] a, input logic [15:0] d);
    part.issue(c, off, a, d, 8'h00, 9'h000);
  endtask
  task automatic rd(input logic [9:0] a);
    op(`MAD_OP_LOAD_TEMP, 1'b0, a, 16'h0000);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_multiply;
    op(`MAD_OP_LOAD_TEMP, 1'b1, 10'h000, 16'hfffe);
    op(`MAD_OP_SIGNED_MULTIPLY, 1'b1, 10'h000, 16'h0003);
    check("signed", productReg, 32'hfffffffa);
    op(`MAD_OP_UNSIGNED_MULTIPLY, 1'b1, 10'h000, 16'hffff);
    check("unsigned", productReg, 32'hfffd0002);
    op(`MAD_OP_SQUARE_AND_ADD, 1'b1, 10'h000, 16'hfffd);
    check("square", productReg, 32'h00000009);
    check("sq add", accum, 32'hfffd0002);
    op(`MAD_OP_SQUARE_AND_SUBTRACT, 1'b1, 10'h000, 16'h0003);
    check("sq sub", accum, 32'hfffcfff9);
    op(`MAD_OP_UNSIGNED_MULTIPLY, 1'b1, 10'h000, 16'hffff);
  endtask
  task automatic t_shift;
    logic [31:0] e [4] = '{32'hfffd0002, 32'hfffa0004, 32'hffd00020, 32'hfffff400};
    for (int m = 0; m < 4; m++) begin
      op(`MAD_OP_CLEAR_ACCUM, 1'b0, 10'h000, 16'h0000);
      @(negedge clk) productShiftField = m[1:0];
      op(`MAD_OP_ADD_PRODUCT_TO_ACCUM, 1'b0, 10'h000, 16'h0000);
      check("shifted", accum, e[m]);
      check("product", productReg, 32'hfffd0002);
      check("field", {30'h0, statusProductShift}, 32'(m));
    end
    @(negedge clk) productShiftField = 2'h0;
  endtask
  task automatic t_move;
    part.put(10'h1ff, 16'h1234);
    part.put(10'h150, 16'haaaa);
    part.put(10'h151, 16'h5555);
    op(`MAD_OP_COPY_WORD_UP, 1'b0, 10'h1ff, 16'h0000);
    check("operand", {16'h0, operandOut}, 32'h00001234);
    op(`MAD_OP_COPY_WORD_UP, 1'b1, 10'h150, 16'h0000);
    rd(10'h151);
    check("off-chip", {16'h0, tempReg}, 32'h00005555);
    op(`MAD_OP_LOAD_TEMP_ACCUM, 1'b0, 10'h150, 16'h0000);
    rd(10'h151);
    check("ltacc", {16'h0, tempReg}, 32'h0000aaaa);
    rd(10'h200);
    check("boundary", {16'h0, tempReg}, 32'h00001234);
  endtask
  // Zeroes product and sum first, so the total is the three products only
  task automatic fir_pass(input logic [9:0] a, input logic [7:0] n);
    op(`MAD_OP_LOAD_TEMP, 1'b1, 10'h000, 16'h0000);
    op(`MAD_OP_SIGNED_MULTIPLY, 1'b1, 10'h000, 16'h0000);
    op(`MAD_OP_CLEAR_ACCUM, 1'b0, 10'h000, 16'h0000);
    if (n == 8'h00) begin
      for (int i = 0; i < 3; i++) begin
        part.issue(`MAD_OP_MUL_ACC_WITH_MOVE, 1'b0, a - 10'(i), 16'h0000, 8'h00, 9'(i));
      end
    end else if (n == 8'hff) begin
      // Plain multiply-accumulate, then a separate copy of the same word
      for (int i = 0; i < 3; i++) begin
        part.issue(`MAD_OP_MUL_ACC, 1'b0, a - 10'(i), 16'h0000, 8'h00, 9'(i));
        op(`MAD_OP_COPY_WORD_UP, 1'b0, a - 10'(i), 16'h0000);
      end
    end else begin
      part.issue(`MAD_OP_MUL_ACC_WITH_MOVE, 1'b0, a, 16'h0000, n, 9'h000);
    end
    op(`MAD_OP_ADD_PRODUCT_TO_ACCUM, 1'b0, 10'h000, 16'h0000);
  endtask
  task automatic t_fir;
    part.put(10'h000, 16'h0002);
    part.put(10'h001, 16'h0003);
    part.put(10'h002, 16'h0005);
    part.put(10'h122, 16'h0007);
    part.put(10'h121, 16'h000b);
    part.put(10'h120, 16'h000d);
    op(`MAD_OP_MAP_BLOCK_ZERO_PROGRAM, 1'b0, 10'h000, 16'h0000);
    check("mapped", {31'h0, blockZeroProgram}, 32'h1);
    fir_pass(10'h122, 8'h00);
    check("sum", accum, 32'h00000070);
    rd(10'h121);
    check("delay", {16'h0, tempReg}, 32'h0000000d);
    fir_pass(10'h123, 8'h02);
    check("sum rep", accum, 32'h00000070);
    rd(10'h124);
    check("delay rep", {16'h0, tempReg}, 32'h00000007);
    fir_pass(10'h124, 8'hff);
    check("sum split", accum, 32'h00000070);
    rd(10'h125);
    check("delay split", {16'h0, tempReg}, 32'h00000007);
    op(`MAD_OP_MAP_BLOCK_ZERO_DATA, 1'b0, 10'h000, 16'h0000);
    check("unmapped", {31'h0, blockZeroProgram}, 32'h0);
  endtask
  initial begin
    rst_b = 1'b0;
    productShiftField = 2'h0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    t_multiply();
    t_shift();
    t_move();
    t_fir();
    give_verdict(1'b0);
  end
endmodule
bind mad_datapath mad_checker chk (.clk(clk), .rst_b(rst_b), .opValid(opValid), .opCode(opCode),
  .repeatCount(repeatCount), .opOffChip(opOffChip), .offChipData(offChipData), .busy(busy), .accum(accum),
  .productReg(productReg), .tempReg(tempReg), .blockZeroProgram(blockZeroProgram),
  .statusProductShift(statusProductShift));
`default_nettype wire
